// [pscp_pkg.sv]
// Constants for the pump serial command port
package pscp_pkg;
   // ----------------------------------------------------------------
   // Clock and link timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam logic [18:0] DIV_300 = 19'(CLK_HZ / 300);
   localparam logic [18:0] DIV_1200 = 19'(CLK_HZ / 1200);
   localparam logic [18:0] DIV_2400 = 19'(CLK_HZ / 2400);
   localparam logic [18:0] DIV_9600 = 19'(CLK_HZ / 9600);
   localparam logic [18:0] DIV_19200 = 19'(CLK_HZ / 19200);
   localparam int GAP_MS = 500;
   localparam int GAP_CYC = GAP_MS * (CLK_HZ / 1000);
   localparam logic [3:0] FRAME_BITS = 4'hA;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_ACTION = 8'h08;
   localparam logic [1:0] WIN_CMD = 2'h1;
   localparam logic [1:0] WIN_RESP = 2'h2;
   localparam int CTRL_BAUD_LSB = 0;
   localparam int CTRL_CHK_BIT = 3;
   localparam int CTRL_STN_LSB = 8;
   localparam int ACT_SEND_BIT = 0;
   localparam int ACT_ALARM_BIT = 1;
   localparam int ACT_SETUP_BIT = 2;
   localparam int ACT_STAT_LSB = 8;
   localparam int ACT_LEN_LSB = 16;
   localparam logic [2:0] BAUD_RST = 3'h4;
   localparam logic [6:0] STN_RST = 7'h00;
   localparam logic [6:0] STN_MAX = 7'h63;
   // ----------------------------------------------------------------
   // Framing characters and CRC
   // ----------------------------------------------------------------
   localparam logic [7:0] CH_STX = 8'h02;
   localparam logic [7:0] CH_ETX = 8'h03;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_SPACE = 8'h20;
   localparam logic [7:0] CH_DEL = 8'h7F;
   localparam logic [7:0] CH_ZERO = 8'h30;
   localparam logic [7:0] LEN_OVERHEAD = 8'h04;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h1021;
endpackage

// [pscp_top.sv]
// Serial command front end: UART, address filter, framing, APB registers
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pscp_top #(
   parameter logic NV_CHECKED = 1'b0,
   parameter int GAP_CYCLES = pscp_pkg::GAP_CYC,
   // Bit times are divided by this; above 1 only to shorten simulation
   parameter int BIT_SCALE = 1
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic host_rxd,
   output logic host_txd,
   input wire logic net_rxd,
   output logic net_txd,
   input wire logic keypad_edit,
   output logic link_indicator
);
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} pscp_rx_t;
   typedef enum logic [2:0] {
      P_IDLE, P_LEN, P_DATA, P_CRC1, P_CRC2, P_ETX
   } pscp_pr_t;
   typedef enum logic [1:0] {T_IDLE, T_LOAD, T_SHIFT} pscp_tx_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [1:0] hsync;
      logic [1:0] nsync;
      logic host_txd;
      logic net_txd;
      logic link;
      logic [2:0] baud;
      logic chk_sel;
      logic [6:0] station;
      pscp_rx_t rx;
      logic [18:0] rx_cnt;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      pscp_pr_t pr;
      logic [25:0] gap;
      logic [7:0] remain;
      logic [15:0] rx_crc;
      logic [7:0] crc_hi;
      logic [1:0] ndig;
      logic [6:0] addr;
      logic [4:0] clen;
      logic [15:0][7:0] cbuf;
      logic pending;
      logic cmd_chk;
      logic [15:0][7:0] rbuf;
      pscp_tx_t tx;
      logic tx_chk;
      logic tx_reply;
      logic [7:0] tx_stat;
      logic [4:0] tx_dlen;
      logic [4:0] tx_idx;
      logic [15:0] tx_crc;
      logic [9:0] tx_sh;
      logic [3:0] tx_bits;
      logic [18:0] tx_cnt;
   } pscp_state_t;
   pscp_state_t s, next_s;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [18:0] pscp_div(input logic [2:0] sel);
      case (sel)
         3'h0: pscp_div = 19'(pscp_pkg::DIV_300 / BIT_SCALE);
         3'h1: pscp_div = 19'(pscp_pkg::DIV_1200 / BIT_SCALE);
         3'h2: pscp_div = 19'(pscp_pkg::DIV_2400 / BIT_SCALE);
         3'h3: pscp_div = 19'(pscp_pkg::DIV_9600 / BIT_SCALE);
         default: pscp_div = 19'(pscp_pkg::DIV_19200 / BIT_SCALE);
      endcase
   endfunction

   function automatic logic [15:0] pscp_crc(input logic [15:0] c,
                                            input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {b, 8'h00};
      for (int i = 0; i < 8; i++) begin
         r = r[15] ? ((r << 1) ^ pscp_pkg::CRC_POLY) : (r << 1);
      end
      pscp_crc = r;
   endfunction

   function automatic logic [7:0] pscp_digit(input logic [6:0] v,
                                             input logic tens);
      logic [6:0] q;
      q = v / 7'h0A;
      pscp_digit = pscp_pkg::CH_ZERO +
         {4'h0, tens ? q[3:0] : 4'(v - q * 7'h0A)};
   endfunction

   logic [18:0] div;
   logic [7:0] rb, ch, pay, txb;
   logic got, rx_line, wr, hit, end_cmd, crc_ok, acc_cmd;
   logic [7:0] plen;
   logic [31:0] rd;

   always_comb begin
      next_s = s;
      div = pscp_div(s.baud);
      got = 1'b0;
      rb = s.rx_sh;
      ch = 8'h00;
      end_cmd = 1'b0;
      crc_ok = 1'b0;
      acc_cmd = 1'b0;
      pay = 8'h00;
      txb = 8'h00;
      plen = 8'h00;
      rd = 32'h0000_0000;
      hit = 1'b1;
      rx_line = s.hsync[1];
      // -------------------------------------------------------------
      // Pin synchronisers and chain pass-through
      // -------------------------------------------------------------
      next_s.hsync = {s.hsync[0], host_rxd};
      next_s.nsync = {s.nsync[0], net_rxd};
      // Idle-high lines: AND merges downstream replies with our own
      next_s.net_txd = s.hsync[1];
      next_s.host_txd = s.nsync[1] & s.tx_sh[0];

      // -------------------------------------------------------------
      // Receiver, mid-bit sampling
      // -------------------------------------------------------------
      if (s.rx_cnt != 19'h00000) begin
         next_s.rx_cnt = s.rx_cnt - 19'h00001;
      end
      case (s.rx)
         RX_IDLE: if (!rx_line) begin
            next_s.rx = RX_START;
            next_s.rx_cnt = div >> 1;
         end
         RX_START: if (s.rx_cnt == 19'h00000) begin
            next_s.rx = rx_line ? RX_IDLE : RX_DATA;
            // Reload one short: the zero count is the bit's last cycle
            next_s.rx_cnt = div - 19'h00001;
            next_s.rx_bit = 3'h0;
         end
         RX_DATA: if (s.rx_cnt == 19'h00000) begin
            next_s.rx_sh = {rx_line, s.rx_sh[7:1]};
            next_s.rx_cnt = div - 19'h00001;
            next_s.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == 3'h7) begin
               next_s.rx = RX_STOP;
            end
         end
         RX_STOP: if (s.rx_cnt == 19'h00000) begin
            next_s.rx = RX_IDLE;
            got = rx_line; // Framing error drops the byte
         end
         default: next_s.rx = RX_IDLE;
      endcase

      // -------------------------------------------------------------
      // Packet parser
      // -------------------------------------------------------------
      if (s.pr != P_IDLE && s.gap != 26'(GAP_CYCLES)) begin
         next_s.gap = s.gap + 26'h0000001;
      end
      if (s.pr != P_IDLE && s.gap == 26'(GAP_CYCLES)) begin
         next_s.pr = P_IDLE;
         next_s.clen = 5'h00;
         next_s.ndig = 2'h0;
      end
      // Bytes arriving while a command is outstanding are lost
      if (got && !s.pending) begin
         next_s.gap = 26'h0000000;
         ch = rb;
         if (s.pr == P_IDLE && rb != pscp_pkg::CH_STX) begin
            // Upper case applies to plain commands only
            if (rb >= 8'h61 && rb <= 8'h7A) begin
               ch = rb - 8'h20;
            end
         end
         case (s.pr)
            P_IDLE: begin
               if (rb == pscp_pkg::CH_STX) begin
                  next_s.pr = P_LEN;
                  next_s.rx_crc = pscp_pkg::CRC_INIT;
                  next_s.clen = 5'h00;
                  next_s.ndig = 2'h0;
               end else if (!s.chk_sel) begin
                  if (rb == pscp_pkg::CH_CR) begin
                     end_cmd = 1'b1;
                     crc_ok = 1'b1;
                  end else if (rb > pscp_pkg::CH_SPACE &&
                               rb != pscp_pkg::CH_DEL) begin
                     got = 1'b1;
                  end else begin
                     got = 1'b0;
                  end
               end else begin
                  got = 1'b0; // Checked framing ignores plain text
               end
               if (rb == pscp_pkg::CH_STX || rb == pscp_pkg::CH_CR) begin
                  got = 1'b0;
               end
            end
            P_LEN: begin
               got = 1'b0;
               next_s.remain = rb - pscp_pkg::LEN_OVERHEAD;
               next_s.pr = (rb < pscp_pkg::LEN_OVERHEAD) ? P_IDLE :
                  (rb == pscp_pkg::LEN_OVERHEAD) ? P_CRC1 : P_DATA;
            end
            P_DATA: begin
               next_s.rx_crc = pscp_crc(s.rx_crc, rb);
               next_s.remain = s.remain - 8'h01;
               if (s.remain == 8'h01) begin
                  next_s.pr = P_CRC1;
               end
            end
            P_CRC1: begin
               got = 1'b0;
               next_s.crc_hi = rb;
               next_s.pr = P_CRC2;
            end
            P_CRC2: begin
               got = 1'b0;
               next_s.pr = P_ETX;
               next_s.rx_crc = {s.crc_hi, rb} ^ s.rx_crc;
            end
            P_ETX: begin
               got = 1'b0;
               end_cmd = 1'b1;
               // Corrupted packets vanish without reply
               crc_ok = rb == pscp_pkg::CH_ETX &&
                  s.rx_crc == 16'h0000;
            end
            default: begin
               got = 1'b0;
               next_s.pr = P_IDLE;
            end
         endcase
         if (got) begin
            // Up to two leading digits form the station number
            if (s.clen == 5'h00 && s.ndig != 2'h2 &&
                ch >= pscp_pkg::CH_ZERO && ch <= 8'h39) begin
               next_s.ndig = s.ndig + 2'h1;
               next_s.addr = 7'(s.addr * 7'h0A + 7'(ch[3:0]));
            end else if (s.clen != 5'h10) begin
               next_s.cbuf[s.clen[3:0]] = ch;
               next_s.clen = s.clen + 5'h01;
            end
         end
         if (end_cmd) begin
            next_s.pr = P_IDLE;
            next_s.ndig = 2'h0;
            next_s.addr = 7'h00;
            // Missing address defaults to zero because addr is cleared at reset and at each command end
            if (crc_ok && s.addr == s.station) begin
               next_s.pending = 1'b1;
               next_s.cmd_chk = s.pr == P_ETX;
               next_s.link = 1'b1;
               acc_cmd = 1'b1;
            end else begin
               next_s.clen = 5'h00;
            end
         end
      end

      // -------------------------------------------------------------
      // APB slave, one wait state
      // -------------------------------------------------------------
      case (paddr[7:6])
         2'h0: case (paddr)
            pscp_pkg::OFS_CTRL: rd = {17'h00000, s.station, 4'h0,
               s.chk_sel, s.baud};
            pscp_pkg::OFS_STATUS: rd = {23'h000000, s.clen,
               s.cmd_chk, s.tx != T_IDLE, s.link,
               s.pending & ~keypad_edit};
            pscp_pkg::OFS_ACTION: rd = 32'h0000_0000;
            default: hit = 1'b0;
         endcase
         pscp_pkg::WIN_CMD: rd = {24'h000000, s.cbuf[paddr[5:2]]};
         pscp_pkg::WIN_RESP: rd = {24'h000000, s.rbuf[paddr[5:2]]};
         default: hit = 1'b0;
      endcase
      next_s.pready = 1'b0;
      next_s.pslverr = 1'b0;
      if (psel && penable && !s.pready) begin
         next_s.pready = 1'b1;
         next_s.pslverr = ~hit;
         next_s.prdata = rd;
      end
      wr = psel && penable && s.pready && pwrite && !s.pslverr;
      if (wr && paddr == pscp_pkg::OFS_CTRL) begin
         next_s.baud = pwdata[pscp_pkg::CTRL_BAUD_LSB +: 3];
         // Takes effect at once, so the next reply is already framed
         next_s.chk_sel = pwdata[pscp_pkg::CTRL_CHK_BIT];
         if (pwdata[pscp_pkg::CTRL_STN_LSB +: 7] <=
             pscp_pkg::STN_MAX) begin
            next_s.station = pwdata[pscp_pkg::CTRL_STN_LSB +: 7];
         end
      end
      if (wr && paddr[7:6] == pscp_pkg::WIN_RESP) begin
         next_s.rbuf[paddr[5:2]] = pwdata[7:0];
      end
      if (wr && paddr == pscp_pkg::OFS_ACTION) begin
         // A command accepted in the same cycle keeps the flag set
         if (pwdata[pscp_pkg::ACT_SETUP_BIT] && !acc_cmd) begin
            next_s.link = 1'b0;
         end
         if (s.tx == T_IDLE &&
             ((pwdata[pscp_pkg::ACT_SEND_BIT] && s.pending &&
               !keypad_edit) ||
              (pwdata[pscp_pkg::ACT_ALARM_BIT] && s.chk_sel))) begin
            // Unsolicited sends need checked framing
            next_s.tx = T_LOAD;
            next_s.tx_chk = s.chk_sel;
            next_s.tx_reply = pwdata[pscp_pkg::ACT_SEND_BIT] &&
               s.pending && !keypad_edit;
            next_s.tx_stat = pwdata[pscp_pkg::ACT_STAT_LSB +: 8];
            next_s.tx_dlen = (pwdata[pscp_pkg::ACT_LEN_LSB +: 5] > 5'h10)
               ? 5'h10 : pwdata[pscp_pkg::ACT_LEN_LSB +: 5];
            next_s.tx_idx = 5'h00;
            next_s.tx_crc = pscp_pkg::CRC_INIT;
         end
      end

      // -------------------------------------------------------------
      // Transmitter and response framing
      // -------------------------------------------------------------
      plen = {3'h0, s.tx_dlen} + 8'h03;
      case (s.tx_idx)
         5'h00: pay = pscp_digit(s.station, 1'b1);
         5'h01: pay = pscp_digit(s.station, 1'b0);
         5'h02: pay = s.tx_stat;
         default: pay = s.rbuf[4'(s.tx_idx - 5'h03)];
      endcase
      if (s.tx_chk) begin
         if (s.tx_idx == 5'h00) txb = pscp_pkg::CH_STX;
         else if (s.tx_idx == 5'h01) txb = plen + pscp_pkg::LEN_OVERHEAD;
         else if ({3'h0, s.tx_idx} < plen + 8'h02) begin
            pay = s.tx_idx == 5'h02 ? pscp_digit(s.station, 1'b1) :
               s.tx_idx == 5'h03 ? pscp_digit(s.station, 1'b0) :
               s.tx_idx == 5'h04 ? s.tx_stat :
               s.rbuf[4'(s.tx_idx - 5'h05)];
            txb = pay;
         end else if ({3'h0, s.tx_idx} == plen + 8'h02) txb = s.tx_crc[15:8];
         else if ({3'h0, s.tx_idx} == plen + 8'h03) txb = s.tx_crc[7:0];
         else txb = pscp_pkg::CH_ETX;
      end else begin
         txb = ({3'h0, s.tx_idx} < plen) ? pay : pscp_pkg::CH_CR;
      end
      if (s.tx_cnt != 19'h00000) begin
         next_s.tx_cnt = s.tx_cnt - 19'h00001;
      end
      case (s.tx)
         T_IDLE: next_s.tx_sh = 10'h3FF;
         T_LOAD: begin
            // Completion shows as the first byte starts
            // Alarms and later bytes must not drop a newer command
            if (s.tx_reply && s.tx_idx == 5'h00) begin
               next_s.pending = 1'b0;
               next_s.clen = 5'h00;
            end
            next_s.tx_sh = {1'b1, txb, 1'b0};
            next_s.tx_bits = pscp_pkg::FRAME_BITS;
            next_s.tx_cnt = div - 19'h00001;
            next_s.tx = T_SHIFT;
            if (s.tx_chk && s.tx_idx >= 5'h02 &&
                {3'h0, s.tx_idx} < plen + 8'h02) begin
               next_s.tx_crc = pscp_crc(s.tx_crc, txb);
            end
         end
         T_SHIFT: if (s.tx_cnt == 19'h00000) begin
            next_s.tx_sh = {1'b1, s.tx_sh[9:1]};
            next_s.tx_cnt = div - 19'h00001;
            next_s.tx_bits = s.tx_bits - 4'h1;
            if (s.tx_bits == 4'h1) begin
               next_s.tx_idx = s.tx_idx + 5'h01;
               next_s.tx = ((s.tx_chk && {3'h0, s.tx_idx} ==
                  plen + 8'h04) || (!s.tx_chk &&
                  {3'h0, s.tx_idx} == plen)) ? T_IDLE : T_LOAD;
            end
         end
         default: next_s.tx = T_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.hsync <= 2'h3;
         s.nsync <= 2'h3;
         s.host_txd <= 1'b1;
         s.net_txd <= 1'b1;
         s.rx_sh <= 8'h00;
         s.tx_sh <= 10'h3FF;
         s.baud <= pscp_pkg::BAUD_RST;
         s.station <= pscp_pkg::STN_RST;
         // Stored framing choice applies straight after power-up
         s.chk_sel <= NV_CHECKED;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign host_txd = s.host_txd;
   assign net_txd = s.net_txd;
   assign link_indicator = s.link;
endmodule
`default_nettype wire

// [pscp_monitor.sv]
// Checker of bus timing, pass-through paths and link flag at the pins
`timescale 1ns/10ps
`default_nettype none
module pscp_monitor (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic host_rxd,
   input wire logic host_txd,
   input wire logic net_rxd,
   input wire logic net_txd,
   input wire logic keypad_edit,
   input wire logic link_indicator
);
   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   // Three-cycle paths must not look back into reset
   logic [2:0] rst_hist;
   logic setup_wr;
   assign setup_wr = psel && penable && pwrite
      && paddr == pscp_pkg::OFS_ACTION && pwdata[pscp_pkg::ACT_SETUP_BIT];
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rst_hist <= 3'h7;
      end else begin
         rst_hist <= {rst_hist[1:0], 1'b0};
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   a_ready_one_wait: assert property (psel && penable && !$past(penable)
      |-> !pready ##1 pready) else $error("pready not after one wait");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held over one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_needs_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_unmapped_err: assert property (pready && paddr inside {[8'h0C:8'h3F]}
      |-> pslverr) else $error("unmapped access not refused");
   a_ctrl_no_err: assert property (pready && paddr == pscp_pkg::OFS_CTRL
      |-> !pslverr) else $error("control access refused");
   a_net_follow: assert property (rst_hist == 3'h0
      |-> net_txd == $past(host_rxd, 3)) else $error("net_txd not host copy");
   a_host_merge: assert property (rst_hist == 3'h0
      && !$past(net_rxd, 3) |-> !host_txd) else $error("net_rxd low lost");
   a_link_hold: assert property ($fell(link_indicator)
      |-> $past(setup_wr, 1) || $past(setup_wr, 2))
      else $error("link flag fell without setup");
endmodule
bind pscp_top pscp_monitor u_mon (.core_clk(core_clk), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .host_rxd(host_rxd), .host_txd(host_txd), .net_rxd(net_rxd),
   .net_txd(net_txd), .keypad_edit(keypad_edit),
   .link_indicator(link_indicator));
`default_nettype wire

// [pscp_host_model.sv]
// Host-side serial partner: sends and receives 8N1 characters
`timescale 1ns/10ps
`default_nettype none
module pscp_host_model #(
   parameter int BIT_CYC = int'(pscp_pkg::DIV_19200)
) (
   input wire logic core_clk,
   output logic host_rxd,
   input wire logic host_txd
);
   // Line rests at mark level between characters
   initial host_rxd = 1'b1;
   // Fixed 19200 rate; the pump never adapts to the host
   task automatic send_byte(input logic [7:0] b);
      host_rxd <= 1'b0;
      repeat (BIT_CYC) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         host_rxd <= b[i];
         repeat (BIT_CYC) @(posedge core_clk);
      end
      host_rxd <= 1'b1;
      repeat (BIT_CYC) @(posedge core_clk);
   endtask
   // Samples mid-bit; a missing stop bit clears ok
   task automatic recv_byte(output logic [7:0] b, output logic ok);
      int n;
      n = 0;
      while (host_txd !== 1'b0 && n < 2000) begin
         @(posedge core_clk);
         n++;
      end
      ok = (n < 2000);
      repeat (BIT_CYC / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYC) @(posedge core_clk);
         b[i] = host_txd;
      end
      repeat (BIT_CYC) @(posedge core_clk);
      ok = ok && (host_txd === 1'b1);
   endtask
endmodule
`default_nettype wire

// [tb_pump_serial_command_port.sv]
// Self-checking bench for the pump serial command port
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
   err_count++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module tb_pump_serial_command_port;
   logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
   logic host_rxd, host_txd, net_rxd, net_txd, keypad_edit, link_indicator;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic e, ok;
   logic [7:0] rb;
   int err_count = 0;
   int compares = 0;
   // Shortens every bit time so the run stays short
   localparam int SCALE = 100;
   pscp_top #(.NV_CHECKED(1'b0), .GAP_CYCLES(2000), .BIT_SCALE(SCALE)) uut (
      .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .host_rxd(host_rxd),
      .host_txd(host_txd), .net_rxd(net_rxd), .net_txd(net_txd),
      .keypad_edit(keypad_edit), .link_indicator(link_indicator));
   pscp_host_model #(.BIT_CYC(int'(pscp_pkg::DIV_19200) / SCALE)) u_host (
      .core_clk(core_clk), .host_rxd(host_rxd), .host_txd(host_txd));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // ----------------------------------------------------------------
   // Bus and report tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("Counts: %0d compares, %0d mismatches", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Entered just after an edge; leaves one idle edge behind it
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic err);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_count++;
         $display("BAD apb wait exp 1 got %b", pready);
         tally_and_finish();
      end else begin
         q = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
      input string nm);
      logic [31:0] q;
      logic err;
      apb(1'b0, a, 32'h0, q, err);
      `CHK(nm, x, q)
      `CHK("read err", 1'b0, err)
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic err;
      apb(1'b1, a, d, q, err);
   endtask
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      net_rxd = 1'b1;
      keypad_edit = 1'b0;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      rd_chk(pscp_pkg::OFS_CTRL, 32'h0000_0004, "ctrl");
      rd_chk(pscp_pkg::OFS_STATUS, 32'h0, "status");
      `CHK("link", 1'b0, link_indicator)
      $display("test reset done");
      for (int i = 0; i < 5; i++) begin
         wr(pscp_pkg::OFS_CTRL, 32'(i));
         rd_chk(pscp_pkg::OFS_CTRL, 32'(i), "baud");
      end
      wr(pscp_pkg::OFS_CTRL, 32'h0000_6304);
      rd_chk(pscp_pkg::OFS_CTRL, 32'h0000_6304, "stn max");
      wr(pscp_pkg::OFS_CTRL, 32'h0000_6404);
      rd_chk(pscp_pkg::OFS_CTRL, 32'h0000_6304, "stn over");
      wr(pscp_pkg::OFS_CTRL, 32'h0000_0004);
      apb(1'b0, 8'h20, 32'h0, rd, e);
      `CHK("unmapped err", 1'b1, e)
      `CHK("unmapped data", 32'h0, rd)
      $display("test registers done");
      wr(pscp_pkg::OFS_ACTION, 32'h0000_3A02);
      repeat (4) @(posedge core_clk);
      rd_chk(pscp_pkg::OFS_STATUS, 32'h0, "no alarm tx");
      `CHK("txd idle", 1'b1, host_txd)
      net_rxd <= 1'b0;
      repeat (4) @(posedge core_clk);
      `CHK("net to host", 1'b0, host_txd)
      net_rxd <= 1'b1;
      repeat (4) @(posedge core_clk);
      `CHK("net idle", 1'b1, host_txd)
      $display("test silence and pass-through done");
      // Set to station 5: one command for station 3, one bare
      wr(pscp_pkg::OFS_CTRL, 32'h0000_0504);
      u_host.send_byte(8'h30);
      u_host.send_byte(8'h33);
      u_host.send_byte(pscp_pkg::CH_CR);
      u_host.send_byte(pscp_pkg::CH_CR);
      rd_chk(pscp_pkg::OFS_STATUS, 32'h0, "other stn");
      wr(pscp_pkg::OFS_CTRL, 32'h0000_0004);
      // Bare terminator: shortest command, addressed to station zero
      u_host.send_byte(pscp_pkg::CH_CR);
      keypad_edit <= 1'b1;
      repeat (4) @(posedge core_clk);
      rd_chk(pscp_pkg::OFS_STATUS, 32'h0000_0002, "edit hold");
      wr(pscp_pkg::OFS_ACTION, 32'h0000_3A01);
      repeat (4) @(posedge core_clk);
      rd_chk(pscp_pkg::OFS_STATUS, 32'h0000_0002, "send held");
      keypad_edit <= 1'b0;
      repeat (2) @(posedge core_clk);
      rd_chk(pscp_pkg::OFS_STATUS, 32'h0000_0003, "cmd ready");
      `CHK("link set", 1'b1, link_indicator)
      wr(pscp_pkg::OFS_ACTION, 32'h0000_3A01);
      u_host.recv_byte(rb, ok);
      `CHK("reply frame", 1'b1, ok)
      `CHK("reply first", pscp_pkg::CH_ZERO, rb)
      rd_chk(pscp_pkg::OFS_STATUS, 32'h0000_0006, "sending");
      wr(pscp_pkg::OFS_ACTION, 32'h0000_0004);
      repeat (2) @(posedge core_clk);
      `CHK("link cleared", 1'b0, link_indicator)
      $display("test command and reply done");
      tally_and_finish();
   end
endmodule
`undef CHK
`default_nettype wire
